// [bcda_cfg.svh]
// Purpose: constants for the bcd/compare/decrement alu datapath
// Assumes: included by the design file only, not by the package
// Notes: status register layout of the host cpu
`ifndef BCDA_CFG_SVH
`define BCDA_CFG_SVH
`define BCDA_SR_C 0
`define BCDA_SR_Z 1
`define BCDA_SR_N 2
`define BCDA_SR_GIE 3
`define BCDA_SR_PROCESSOR_HALT_BIT 4
`define BCDA_SR_OSCILLATOR_OFF_BIT 5
`define BCDA_SR_V 8
`define BCDA_CLEAR_ZERO_FLAG_OP_MASK 16'hFFFD
`define BCDA_CLEAR_ZERO_FLAG_OP_CONST 16'h0002
`define BCDA_WORD_MSB 15
`define BCDA_BYTE_MSB 7
`define BCDA_PTR_STEP 20'h00002
`define BCDA_DEC_ONE 16'h0001
`define BCDA_DEC_TWO 16'h0002
`define BCDA_W_MIN 16'h8000
`define BCDA_W_MIN1 16'h8001
`define BCDA_B_MIN 16'h0080
`define BCDA_B_MIN1 16'h0081
`define BCDA_BCD_DIGITS 4
`define BCDA_BYTE_DIGITS 2
`define BCDA_DIGIT_W 4
`define BCDA_BCD_DIGIT_MAX 5'h09
`define BCDA_BCD_ADJUST 5'h06
`endif

// [bcda_pkg.sv]
// Purpose: types for the bcd/compare/decrement alu datapath
// Assumes: bcda_cfg.svh holds the numbers
// Notes: opcode codes are internal to this block
package bcda_pkg;
  typedef enum logic [2:0] {
    BCDA_OP_CLEAR_ZERO_FLAG_OP = 3'h0,
    BCDA_OP_CMP = 3'h1,
    BCDA_OP_DECIMAL_ADD_CARRY_OP = 3'h2,
    BCDA_OP_DECIMAL_ADD_OP = 3'h3,
    BCDA_OP_DEC = 3'h4,
    BCDA_OP_DOUBLE_DECREMENT_OP = 3'h5,
    BCDA_OP_CALLI = 3'h6,
    BCDA_OP_CALLX = 3'h7
  } bcda_op_t;
endpackage

// [bcda_alu.sv]
// Purpose: one-cycle execute datapath for clear-zero, compare, decimal add,
//   decrement, double decrement and two call address forms
// Assumes: decode supplies operands; memory reads are done by the caller
//   all inputs come from same-clock decode logic, so none is synchronised
// Notes: results and flags are registered, valid one cycle after START_I
//   decimal ops trust their digits: non-bcd input gives undefined sums
`timescale 1ns/100ps
`include "bcda_cfg.svh"

module bcda_alu (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic START_I,
  input wire logic [2:0] OP_I,
  input wire logic BYTE_I,
  input wire logic [15:0] SRC_I,
  input wire logic [19:0] DST_I,
  input wire logic [15:0] SR_I,
  input wire logic [19:0] PTR_I,
  input wire logic [15:0] INDEX_I,
  input wire logic [15:0] MEM_WORD_I,
  output logic DONE_O,
  output logic [19:0] RESULT_O,
  output logic RESULT_WE_O,
  output logic [15:0] SR_O,
  output logic [19:0] PTR_O,
  output logic PTR_WE_O,
  output logic [19:0] MEM_ADDR_O,
  output logic [19:0] PC_O,
  output logic PC_WE_O
);
  logic done_r;
  logic [19:0] result_r;
  logic result_we_r;
  logic [15:0] sr_r;
  logic [19:0] ptr_r;
  logic ptr_we_r;
  logic [19:0] mem_addr_r;
  logic [19:0] pc_r;
  logic pc_we_r;

  // datapath nets
  bcda_pkg::bcda_op_t op;
  logic [15:0] dst16;
  logic [15:0] opnd_b;
  logic [16:0] bin_sum;
  logic [15:0] add_src;
  logic [`BCDA_BCD_DIGITS:0] digit_cy;
  logic [15:0] bcd_raw;
  logic [15:0] bcd_sum;
  logic bcd_cy;
  logic [15:0] res16;
  logic msb_res;
  logic msb_dst;
  logic msb_b;
  logic cy_out;
  logic res_zero;

  // next values of the registered outputs
  logic [15:0] sr_nxt;
  logic [19:0] result_nxt;
  logic result_we_nxt;
  logic [19:0] ptr_nxt;
  logic ptr_we_nxt;
  logic [19:0] addr_nxt;
  logic [19:0] pc_nxt;
  logic pc_we_nxt;

  // all eight codes are defined, so the cast never leaves the enum
  assign op = bcda_pkg::bcda_op_t'(OP_I);
  // byte form sees only the low byte; a written byte result has its upper bits cleared
  assign dst16 = BYTE_I ? {8'h00, DST_I[7:0]} : DST_I[15:0];

  // second binary operand: inverted source for compare, constants for decrements
  always_comb begin
    case (op)
      bcda_pkg::BCDA_OP_CMP: opnd_b = ~SRC_I;
      bcda_pkg::BCDA_OP_DEC: opnd_b = ~`BCDA_DEC_ONE;
      bcda_pkg::BCDA_OP_DOUBLE_DECREMENT_OP: opnd_b = ~`BCDA_DEC_TWO;
      // other ops leave the binary adder idle
      default: opnd_b = 16'h0000;
    endcase
  end

  // subtraction as dst + ~b + 1; byte form carries out of bit 7
  always_comb begin
    logic [15:0] b;
    logic [8:0] s8;
    b = BYTE_I ? {8'h00, opnd_b[7:0]} : opnd_b;
    s8 = {1'b0, dst16[7:0]} + {1'b0, b[7:0]} + 9'h001;
    // byte sum kept apart so its carry lands on bit 8, not bit 16
    if (BYTE_I) begin
      bin_sum = {8'h00, s8};
    end else begin
      bin_sum = {1'b0, dst16} + {1'b0, b} + 17'h00001;
    end
  end

  // decimal adder: one cell per digit, the carry ripples upward
  // carry into the lowest digit is the status carry
  assign digit_cy[0] = SR_I[`BCDA_SR_C];
  assign add_src = (op == bcda_pkg::BCDA_OP_DECIMAL_ADD_OP) ? SRC_I : 16'h0000;
  generate
    for (genvar g = 0; g < `BCDA_BCD_DIGITS; g++) begin : gen_digit
      logic [4:0] sum_bin;
      logic [4:0] sum_adj;
      assign sum_bin = {1'b0, dst16[g*`BCDA_DIGIT_W +: `BCDA_DIGIT_W]}
        + {1'b0, add_src[g*`BCDA_DIGIT_W +: `BCDA_DIGIT_W]} + {4'h0, digit_cy[g]};
      // sums above nine skip the six codes a digit never uses
      assign sum_adj = (sum_bin > `BCDA_BCD_DIGIT_MAX) ? sum_bin + `BCDA_BCD_ADJUST : sum_bin;
      assign bcd_raw[g*`BCDA_DIGIT_W +: `BCDA_DIGIT_W] = sum_adj[3:0];
      assign digit_cy[g + 1] = sum_adj[4];
    end
  endgenerate
  // byte form keeps two digits; the upper cells still run but are dropped
  assign bcd_sum = BYTE_I ? {8'h00, bcd_raw[7:0]} : bcd_raw;
  assign bcd_cy = BYTE_I ? digit_cy[`BCDA_BYTE_DIGITS] : digit_cy[`BCDA_BCD_DIGITS];

  // decimal ops take the digit chain's carry, the rest the binary adder's
  always_comb begin
    if (op == bcda_pkg::BCDA_OP_DECIMAL_ADD_CARRY_OP || op == bcda_pkg::BCDA_OP_DECIMAL_ADD_OP) begin
      res16 = bcd_sum;
      cy_out = bcd_cy;
    end else begin
      res16 = BYTE_I ? {8'h00, bin_sum[7:0]} : bin_sum[15:0];
      cy_out = BYTE_I ? bin_sum[8] : bin_sum[16];
    end
    msb_res = BYTE_I ? res16[`BCDA_BYTE_MSB] : res16[`BCDA_WORD_MSB];
    // operand signs feed the compare overflow test
    msb_dst = BYTE_I ? dst16[`BCDA_BYTE_MSB] : dst16[`BCDA_WORD_MSB];
    msb_b = BYTE_I ? opnd_b[`BCDA_BYTE_MSB] : opnd_b[`BCDA_WORD_MSB];
    res_zero = (res16 == 16'h0000);
  end

  // flag and result selection; mode bits only pass through
  always_comb begin
    sr_nxt = SR_I;
    result_nxt = DST_I;
    result_we_nxt = 1'b0;
    ptr_nxt = PTR_I;
    ptr_we_nxt = 1'b0;
    addr_nxt = 20'h00000;
    // pc image keeps its value unless a call loads it
    pc_nxt = pc_r;
    pc_we_nxt = 1'b0;
    case (op)
      bcda_pkg::BCDA_OP_CLEAR_ZERO_FLAG_OP: begin
        // mask covers the whole word, so every other bit passes unchanged
        sr_nxt = SR_I & `BCDA_CLEAR_ZERO_FLAG_OP_MASK;
      end
      bcda_pkg::BCDA_OP_CMP: begin
        sr_nxt[`BCDA_SR_N] = msb_res;
        sr_nxt[`BCDA_SR_Z] = res_zero;
        sr_nxt[`BCDA_SR_C] = cy_out;
        // inverted source msb equal to dst msb means src and dst differ in sign
        sr_nxt[`BCDA_SR_V] = (msb_dst == msb_b) && (msb_res != msb_dst);
        // no write enable: the whole register image, upper bits too, stays
        result_nxt = DST_I;
      end
      bcda_pkg::BCDA_OP_DECIMAL_ADD_CARRY_OP, bcda_pkg::BCDA_OP_DECIMAL_ADD_OP: begin
        sr_nxt[`BCDA_SR_N] = msb_res;
        sr_nxt[`BCDA_SR_Z] = res_zero;
        sr_nxt[`BCDA_SR_C] = cy_out;
        // overflow is undefined here; left as it was
        result_nxt = {4'h0, res16};
        result_we_nxt = 1'b1;
      end
      bcda_pkg::BCDA_OP_DEC, bcda_pkg::BCDA_OP_DOUBLE_DECREMENT_OP: begin
        sr_nxt[`BCDA_SR_N] = msb_res;
        sr_nxt[`BCDA_SR_Z] = res_zero;
        // carry is the inverted borrow: clear only when dst was below the step
        sr_nxt[`BCDA_SR_C] = cy_out;
        // overflow only from the most negative start values
        if (op == bcda_pkg::BCDA_OP_DEC) begin
          sr_nxt[`BCDA_SR_V] = BYTE_I ? (dst16 == `BCDA_B_MIN)
                                      : (dst16 == `BCDA_W_MIN);
        end else begin
          sr_nxt[`BCDA_SR_V] = BYTE_I ?
            (dst16 == `BCDA_B_MIN || dst16 == `BCDA_B_MIN1) :
            (dst16 == `BCDA_W_MIN || dst16 == `BCDA_W_MIN1);
        end
        result_nxt = {4'h0, res16};
        result_we_nxt = 1'b1;
      end
      bcda_pkg::BCDA_OP_CALLI: begin
        addr_nxt = PTR_I;
        pc_nxt = {4'h0, MEM_WORD_I};
        pc_we_nxt = 1'b1;
        // pointer steps one word on after the target is read
        ptr_nxt = PTR_I + `BCDA_PTR_STEP;
        ptr_we_nxt = 1'b1;
      end
      bcda_pkg::BCDA_OP_CALLX: begin
        // signed 16-bit index limits reach to plus or minus 32K
        addr_nxt = PTR_I + {{4{INDEX_I[15]}}, INDEX_I};
        // indexed form reads through the base but never writes it back
        pc_nxt = {4'h0, MEM_WORD_I};
        pc_we_nxt = 1'b1;
      end
      default: begin
        sr_nxt = SR_I;
      end
    endcase
  end

  // one register group per concern; write pulses drop back every cycle
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      done_r <= 1'b0;
    end else begin
      done_r <= START_I;
    end
  end

  // result image holds until the next accepted operation
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      result_r <= 20'h00000;
      result_we_r <= 1'b0;
    end else begin
      result_we_r <= START_I && result_we_nxt;
      if (START_I) begin
        result_r <= result_nxt;
      end
    end
  end

  // status only moves on an accepted operation
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      sr_r <= 16'h0000;
    end else begin
      if (START_I) begin
        sr_r <= sr_nxt;
      end
    end
  end

  // pointer image follows every operation; only the post-increment call writes it
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ptr_r <= 20'h00000;
      ptr_we_r <= 1'b0;
    end else begin
      ptr_we_r <= START_I && ptr_we_nxt;
      if (START_I) begin
        ptr_r <= ptr_nxt;
      end
    end
  end

  // address the call target word came from
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      mem_addr_r <= 20'h00000;
    end else begin
      if (START_I) begin
        mem_addr_r <= addr_nxt;
      end
    end
  end

  // pc keeps its last target between calls
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pc_r <= 20'h00000;
      pc_we_r <= 1'b0;
    end else begin
      pc_we_r <= START_I && pc_we_nxt;
      if (START_I) begin
        pc_r <= pc_nxt;
      end
    end
  end

  // each port is a plain copy of its flip-flop
  assign DONE_O = done_r;
  assign RESULT_O = result_r;
  assign RESULT_WE_O = result_we_r;
  assign SR_O = sr_r;
  assign PTR_O = ptr_r;
  assign PTR_WE_O = ptr_we_r;
  assign MEM_ADDR_O = mem_addr_r;
  assign PC_O = pc_r;
  assign PC_WE_O = pc_we_r;
endmodule

// [bcda_alu_monitor.sv]
// Purpose: checker for bcda_alu
// Assumes: one clock, async active-high reset
// Notes: arithmetic flag checks in word form only, the bench covers bytes
`timescale 1ns/100ps
module bcda_alu_monitor (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic START_I,
  input wire logic [2:0] OP_I,
  input wire logic BYTE_I,
  input wire logic [15:0] SRC_I,
  input wire logic [19:0] DST_I,
  input wire logic [15:0] SR_I,
  input wire logic [19:0] PTR_I,
  input wire logic [15:0] INDEX_I,
  input wire logic [15:0] MEM_WORD_I,
  input wire logic [19:0] RESULT_O,
  input wire logic RESULT_WE_O,
  input wire logic [15:0] SR_O,
  input wire logic [19:0] PTR_O,
  input wire logic PTR_WE_O,
  input wire logic [19:0] MEM_ADDR_O,
  input wire logic [19:0] PC_O,
  input wire logic PC_WE_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  clear_zero_a: assert property (START_I && OP_I == 3'h0 |=>
    SR_O == ($past(SR_I) & 16'hFFFD)) else $error("clear zero mask wrong");
  call_step_a: assert property (START_I && OP_I == 3'h6 |=> PTR_WE_O &&
    PTR_O == $past(PTR_I) + 20'h00002) else $error("pointer step wrong");
  call_index_a: assert property (START_I && OP_I == 3'h7 |=>
    MEM_ADDR_O == $past(PTR_I) + {{4{$past(INDEX_I[15])}}, $past(INDEX_I)} &&
    PC_O == {4'h0, $past(MEM_WORD_I)}) else $error("indexed target wrong");
  compare_keep_a: assert property (START_I && OP_I == 3'h1 |=>
    !RESULT_WE_O && RESULT_O == $past(DST_I)) else $error("compare wrote");
  compare_zero_a: assert property (START_I && OP_I == 3'h1 && !BYTE_I |=>
    SR_O[1] == ($past(SRC_I) == $past(DST_I[15:0]))) else $error("compare zero");
  compare_carry_a: assert property (START_I && OP_I == 3'h1 && !BYTE_I |=>
    SR_O[0] == ($past(DST_I[15:0]) >= $past(SRC_I))) else $error("compare carry");
  decr_ovf_a: assert property (START_I && OP_I == 3'h4 && !BYTE_I |=>
    SR_O[8] == ($past(DST_I[15:0]) == 16'h8000)) else $error("decrement overflow");
  double_zero_a: assert property (START_I && OP_I == 3'h5 && !BYTE_I |=>
    SR_O[1] == ($past(DST_I[15:0]) == 16'h0002)) else $error("double zero flag");
  mode_keep_a: assert property (START_I |=> SR_O[5:3] == $past(SR_I[5:3]))
    else $error("mode bits changed");
  call_load_a: assert property (START_I && OP_I[2:1] == 2'h3 |=> PC_WE_O)
    else $error("call target not loaded");
  decimal_add_op_sign_a: assert property (START_I && OP_I == 3'h3 && !BYTE_I |=>
    SR_O[2] == RESULT_O[15]) else $error("decimal sign wrong");
  cover property (START_I && OP_I == 3'h3);
  cover property (START_I && OP_I == 3'h6);
  cover property (START_I && OP_I == 3'h4 && DST_I[15:0] == 16'h8000);
endmodule
bind bcda_alu bcda_alu_monitor bcda_alu_monitor_i (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I),
  .START_I(START_I), .OP_I(OP_I), .BYTE_I(BYTE_I), .SRC_I(SRC_I), .DST_I(DST_I),
  .SR_I(SR_I), .PTR_I(PTR_I), .INDEX_I(INDEX_I), .MEM_WORD_I(MEM_WORD_I),
  .RESULT_O(RESULT_O), .RESULT_WE_O(RESULT_WE_O), .SR_O(SR_O), .PTR_O(PTR_O),
  .PTR_WE_O(PTR_WE_O), .MEM_ADDR_O(MEM_ADDR_O), .PC_O(PC_O), .PC_WE_O(PC_WE_O));

// [tb_top.sv]
// Purpose: directed bench for bcda_alu
// Assumes: answer lands one cycle after the start pulse
// Notes: one idle cycle between operations keeps the driver simple
`timescale 1ns/100ps
module tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic byte_f = 1'b0;
  logic [2:0] op = 3'h0;
  logic [15:0] src = 16'h0000, stat = 16'h0000, idx = 16'h0000, mem = 16'h0000;
  logic [19:0] dst = 20'h00000, ptr = 20'h00000;
  logic done, res_we, ptr_we, pc_we;
  logic [15:0] stat_o;
  logic [19:0] res, ptr_o, addr, pc;
  int fail_count = 0;
  int tests_run = 0;
  always #2.5 mclk = ~mclk;
  bcda_alu bcda_alu_i (.MCLK_I(mclk), .SYS_RST_I(rst), .START_I(start), .OP_I(op),
    .BYTE_I(byte_f), .SRC_I(src), .DST_I(dst), .SR_I(stat), .PTR_I(ptr), .INDEX_I(idx),
    .MEM_WORD_I(mem), .DONE_O(done), .RESULT_O(res), .RESULT_WE_O(res_we), .SR_O(stat_o),
    .PTR_O(ptr_o), .PTR_WE_O(ptr_we), .MEM_ADDR_O(addr), .PC_O(pc), .PC_WE_O(pc_we));
  task chk(input string n, input logic [19:0] e, input logic [19:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task run(input logic [2:0] o, input logic b, input logic [15:0] s, input logic [19:0] d,
    input logic [15:0] f, input logic [19:0] er, input logic [15:0] ef);
    @(posedge mclk);
    #1;
    op = o;
    byte_f = b;
    src = s;
    dst = d;
    stat = f;
    start = 1'b1;
    @(posedge mclk);
    #1;
    start = 1'b0;
    chk("done", 20'h00001, {19'h0, done});
    chk("result write", {19'h0, o inside {3'h2, 3'h3, 3'h4, 3'h5}}, {19'h0, res_we});
    if (o inside {[3'h1:3'h5]}) chk("result", er, res);
    chk("status", {4'h0, ef}, {4'h0, stat_o});
    chk("pointer write", {19'h0, o == 3'h6}, {19'h0, ptr_we});
    chk("pc write", {19'h0, o inside {3'h6, 3'h7}}, {19'h0, pc_we});
  endtask
  task wrap_up;
    $display("mismatches %0d, checks %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #3000;
    fail_count++;
    wrap_up;
  end
  initial begin
    repeat (12) @(posedge mclk);
    #1;
    rst = 1'b0;
    run(3'h0, 1'b0, 16'h0000, 20'h00000, 16'h013F, 20'h00000, 16'h013D);
    run(3'h1, 1'b0, 16'h1234, 20'hA1234, 16'h0000, 20'hA1234, 16'h0003);
    run(3'h1, 1'b0, 16'h8000, 20'h07FFF, 16'h0000, 20'h07FFF, 16'h0104);
    run(3'h1, 1'b1, 16'h0001, 20'h12380, 16'h0000, 20'h12380, 16'h0101);
    run(3'h2, 1'b0, 16'h0000, 20'h09999, 16'h0039, 20'h00000, 16'h003B);
    run(3'h2, 1'b1, 16'h0000, 20'h00099, 16'h0001, 20'h00000, 16'h0003);
    run(3'h3, 1'b0, 16'h0001, 20'h07999, 16'h0000, 20'h08000, 16'h0004);
    run(3'h3, 1'b1, 16'h0055, 20'h00045, 16'h0001, 20'h00001, 16'h0001);
    run(3'h4, 1'b0, 16'h0000, 20'h08000, 16'h0000, 20'h07FFF, 16'h0101);
    run(3'h4, 1'b0, 16'h0000, 20'h00001, 16'h0000, 20'h00000, 16'h0003);
    run(3'h4, 1'b1, 16'h0000, 20'h00000, 16'h0000, 20'h000FF, 16'h0004);
    run(3'h5, 1'b0, 16'h0000, 20'h08001, 16'h0000, 20'h07FFF, 16'h0101);
    run(3'h5, 1'b1, 16'h0000, 20'h00002, 16'h0000, 20'h00000, 16'h0003);
    run(3'h5, 1'b0, 16'h0000, 20'h00001, 16'h0000, 20'h0FFFF, 16'h0004);
    ptr = 20'h12340;
    mem = 16'hBEEF;
    run(3'h6, 1'b0, 16'h0000, 20'h00000, 16'h0038, 20'h00000, 16'h0038);
    chk("pointer", 20'h12342, ptr_o);
    chk("target address", 20'h12340, addr);
    chk("pc", 20'h0BEEF, pc);
    ptr = 20'h10000;
    idx = 16'hFFFE;
    mem = 16'h1234;
    run(3'h7, 1'b0, 16'h0000, 20'h00000, 16'h0000, 20'h00000, 16'h0000);
    chk("target address", 20'h0FFFE, addr);
    chk("pc", 20'h01234, pc);
    rst = 1'b1;
    @(posedge mclk);
    #1;
    chk("reset status", 20'h00000, {4'h0, stat_o});
    chk("reset pc", 20'h00000, pc);
    rst = 1'b0;
    run(3'h4, 1'b1, 16'h0000, 20'h00080, 16'h0000, 20'h0007F, 16'h0101);
    run(3'h5, 1'b1, 16'h0000, 20'h00081, 16'h0000, 20'h0007F, 16'h0101);
    wrap_up;
  end
endmodule
